// ---- hdl/phw_consts.svh ----
// constants of the pcm highway port
`ifndef PHW_CONSTS_SVH
`define PHW_CONSTS_SVH
// register offsets
`define PHW_A_IRQEN 8'h05
`define PHW_A_ADJ 8'h22
`define PHW_A_MODE 8'h23
`define PHW_A_TTS 8'h1a
`define PHW_A_RTS 8'h1b
`define PHW_A_TCS 8'h1c
`define PHW_A_RCS 8'h1d
`define PHW_A_RATE 8'h1e
`define PHW_A_STAT 8'h1f
`define PHW_A_PLLH 8'h18
`define PHW_A_PLLL 8'h19
// field positions
`define PHW_B_IRQEN 4
`define PHW_B_ADJ 6
`define PHW_B_LAW 0
`define PHW_B_LIN 1
`define PHW_B_MASTER 6
`define PHW_B_POL 3
`define PHW_B_SR 0
`define PHW_B_WB 1
`define PHW_B_LOCK 0
`define PHW_B_ERR 1
`define PHW_B_DONE 2
// reset values
`define PHW_RST_IRQEN 1'b1
// frame counts, default bit clocks per frame and last divided period of a master frame
`define PHW_N_DISCARD 4'h8
`define PHW_N_MEASURE 4'h8
`define PHW_N_LOCK 5'h14
`define PHW_DEF_RATE 11'h100
`define PHW_M_FRAME_LAST 8'hfe
// slot lengths in bit slots
`define PHW_LEN_BYTE 6'h08
`define PHW_LEN_WORD 6'h10
`define PHW_LEN_PAIR 6'h20
`endif

// ---- hdl/phw_pkg.sv ----
// types of the pcm highway port
package phw_pkg;
    // rate detection progress, gray coded
    typedef enum logic [1:0] {
        PHW_DISCARD = 2'b00,
        PHW_MEASURE = 2'b01,
        PHW_DONE = 2'b11
    } phw_det_t;
endpackage

// ---- hdl/phw_compander.sv ----
// g.711 a-law and mu-law compressor and expander
`timescale 1ns/10ps
`default_nettype none
module phw_compander (
    // control
    input wire logic i_mu_law,
    // linear to code
    input wire logic [15:0] i_linear,
    output logic [7:0] o_code,
    // code to linear
    input wire logic [7:0] i_code,
    output logic [15:0] o_linear
);
    // highest set bit of a 13-bit magnitude
    function automatic logic [3:0] msb13(input logic [12:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 13; i++)
            if (v[i]) p = 4'(i);
        return p;
    endfunction

    // a-law compression
    function automatic logic [7:0] a_enc(input logic [15:0] x);
        logic [11:0] m;
        logic [3:0] p;
        logic [2:0] seg;
        logic [3:0] man;
        m = x[15] ? ~x[14:3] : x[14:3];
        p = msb13({1'b0, m});
        seg = (p < 4'h5) ? 3'h0 : 3'(p - 4'h4);
        man = (seg == 3'h0) ? m[4:1] : 4'(m >> seg);
        return {~x[15], seg, man} ^ 8'h55;
    endfunction

    // mu-law compression
    function automatic logic [7:0] u_enc(input logic [15:0] x);
        logic [13:0] m;
        logic [12:0] b;
        logic [3:0] p;
        logic [2:0] seg;
        m = x[15] ? 14'(~x[15:2] + 14'h1) : x[15:2];
        b = (m > 14'h1fbe) ? 13'h1fff : 13'(m + 14'h21);
        p = msb13(b);
        seg = 3'(p - 4'h5);
        return {1'b0, seg, 4'(b >> (p - 4'h4))} ^ (x[15] ? 8'h7f : 8'hff);
    endfunction

    // a-law expansion
    function automatic logic [15:0] a_dec(input logic [7:0] c);
        logic [7:0] a;
        logic [15:0] t;
        a = c ^ 8'h55;
        t = {8'h00, a[3:0], 4'h0};
        t = (a[6:4] == 3'h0) ? t + 16'h8 : (t + 16'h108) << (a[6:4] - 3'h1);
        return a[7] ? t : 16'(-t);
    endfunction

    // mu-law expansion
    function automatic logic [15:0] u_dec(input logic [7:0] c);
        logic [7:0] u;
        logic [15:0] t;
        u = ~c;
        t = ({9'h000, u[3:0], 3'h0} + 16'h84) << u[6:4];
        return u[7] ? 16'(16'h84 - t) : 16'(t - 16'h84);
    endfunction

    // law select
    assign o_code = i_mu_law ? u_enc(i_linear) : a_enc(i_linear);
    assign o_linear = i_mu_law ? u_dec(i_code) : a_dec(i_code);
endmodule // phw_compander
`default_nettype wire

// ---- hdl/phw_port.sv ----
// pcm highway port with slot timing, rate detection and master mode
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "phw_consts.svh"
module phw_port #(
    parameter int CW = 11
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // highway clock and frame
    input wire logic i_bit_clock_input_pin,
    output logic o_bit_clock_output_pin,
    input wire logic i_frame_boundary_strobe,
    output logic o_frame_boundary_strobe,
    output logic o_frame_boundary_strobe_oe_n,
    // highway data
    input wire logic i_serial_in_line,
    output logic o_serial_out_line,
    output logic o_serial_out_line_oe_n,
    output logic o_buffer_drive_strobe_n,
    // samples
    input wire logic [15:0] i_tx_sample0,
    input wire logic [15:0] i_tx_sample1,
    output logic [15:0] o_rx_sample0,
    output logic [15:0] o_rx_sample1,
    output logic o_rx_valid,
    // status
    output logic o_clock_detect_error_irq
);
    // ************************************************
    // helpers
    // ************************************************
    // slot window test
    function automatic logic in_win(input logic [CW-1:0] c,
        input logic [CW-1:0] s, input logic [5:0] n);
        return (c >= s) && (c < s + CW'(n));
    endfunction

    // supported bit clocks per frame
    function automatic logic rate_ok(input logic [CW-1:0] c);
        unique case (c)
            CW'(32), CW'(64), CW'(96), CW'(128), CW'(192), CW'(193),
            CW'(256), CW'(386), CW'(512), CW'(772), CW'(1024): return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ************************************************
    // registers
    // ************************************************
    logic irq_en_reg, adj_reg, law_reg, lin_reg, master_reg;
    logic [7:0] tts_reg, rts_reg;
    logic [2:0] tcs_reg, rcs_reg;
    logic transmit_edge_polarity_reg, receive_edge_polarity_reg, sr_reg, wb_reg;
    logic err_reg, lock_reg;
    logic [CW-1:0] pll_reg;
    phw_pkg::phw_det_t det_reg;
    logic err_set;
    logic err_clr;

    // software writes
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            irq_en_reg <= `PHW_RST_IRQEN;
            adj_reg <= 1'b0;
            law_reg <= 1'b0;
            lin_reg <= 1'b0;
            master_reg <= 1'b0;
            tts_reg <= 8'h00;
            rts_reg <= 8'h00;
            tcs_reg <= 3'h0;
            rcs_reg <= 3'h0;
            transmit_edge_polarity_reg <= 1'b0;
            receive_edge_polarity_reg <= 1'b0;
            sr_reg <= 1'b0;
            wb_reg <= 1'b0;
        end
        else if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                `PHW_A_IRQEN: irq_en_reg <= i_reg_wdata[`PHW_B_IRQEN];
                `PHW_A_ADJ: adj_reg <= i_reg_wdata[`PHW_B_ADJ];
                `PHW_A_MODE:
                begin
                    law_reg <= i_reg_wdata[`PHW_B_LAW];
                    lin_reg <= i_reg_wdata[`PHW_B_LIN];
                    master_reg <= i_reg_wdata[`PHW_B_MASTER];
                end
                `PHW_A_TTS: tts_reg <= i_reg_wdata;
                `PHW_A_RTS: rts_reg <= i_reg_wdata;
                `PHW_A_TCS:
                begin
                    tcs_reg <= i_reg_wdata[2:0];
                    transmit_edge_polarity_reg <= i_reg_wdata[`PHW_B_POL];
                end
                `PHW_A_RCS:
                begin
                    rcs_reg <= i_reg_wdata[2:0];
                    receive_edge_polarity_reg <= i_reg_wdata[`PHW_B_POL];
                end
                `PHW_A_RATE:
                begin
                    sr_reg <= i_reg_wdata[`PHW_B_SR];
                    wb_reg <= i_reg_wdata[`PHW_B_WB];
                end
                default: ;
            endcase
        end
    end

    // write one clears the error flag
    assign err_clr = i_reg_wr && (i_reg_addr == `PHW_A_STAT) && i_reg_wdata[`PHW_B_ERR];

    // read data one cycle after the strobe
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                `PHW_A_IRQEN: o_reg_rdata <= 8'(irq_en_reg) << `PHW_B_IRQEN;
                `PHW_A_ADJ: o_reg_rdata <= 8'(adj_reg) << `PHW_B_ADJ;
                `PHW_A_MODE: o_reg_rdata <= (8'(master_reg) << `PHW_B_MASTER)
                    | (8'(lin_reg) << `PHW_B_LIN) | 8'(law_reg);
                `PHW_A_TTS: o_reg_rdata <= tts_reg;
                `PHW_A_RTS: o_reg_rdata <= rts_reg;
                `PHW_A_TCS: o_reg_rdata <= {4'h0, transmit_edge_polarity_reg, tcs_reg};
                `PHW_A_RCS: o_reg_rdata <= {4'h0, receive_edge_polarity_reg, rcs_reg};
                `PHW_A_RATE: o_reg_rdata <= {6'h00, wb_reg, sr_reg};
                `PHW_A_STAT: o_reg_rdata <= {5'h00, det_reg == phw_pkg::PHW_DONE,
                    err_reg, lock_reg};
                `PHW_A_PLLH: o_reg_rdata <= 8'(pll_reg >> 8);
                `PHW_A_PLLL: o_reg_rdata <= pll_reg[7:0];
                default: o_reg_rdata <= 8'h00;
            endcase
        end
        else
            o_reg_rdata <= 8'h00;
    end

    // ************************************************
    // clock source and master generator
    // ************************************************
    logic mclk_in_reg, mdiv_reg, fs_gen_reg;
    logic [7:0] mcnt_reg;
    logic bclk, fs, bclk_d_reg, fs_d_reg;
    logic b_rise, b_fall, fs_rise;

    // divide the 4.096 MHz input by two in master mode
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            mclk_in_reg <= 1'b0;
            mdiv_reg <= 1'b0;
            mcnt_reg <= 8'h00;
            fs_gen_reg <= 1'b0;
        end
        else
        begin
            mclk_in_reg <= i_bit_clock_input_pin;
            if (master_reg && i_bit_clock_input_pin && !mclk_in_reg)
            begin
                mdiv_reg <= ~mdiv_reg;
                if (mdiv_reg)
                begin
                    // strobe spans one divided period per frame
                    fs_gen_reg <= (mcnt_reg == `PHW_M_FRAME_LAST);
                    mcnt_reg <= mcnt_reg + 8'h01;
                end
            end
        end
    end

    // master drives its strobe, slave leaves the pin
    assign o_bit_clock_output_pin = mdiv_reg;
    assign o_frame_boundary_strobe = fs_gen_reg;
    assign o_frame_boundary_strobe_oe_n = ~master_reg;

    // selected bit clock and frame strobe
    assign bclk = master_reg ? mdiv_reg : i_bit_clock_input_pin;
    assign fs = master_reg ? fs_gen_reg : i_frame_boundary_strobe;

    // edge detection
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            bclk_d_reg <= 1'b0;
            fs_d_reg <= 1'b0;
        end
        else
        begin
            bclk_d_reg <= bclk;
            fs_d_reg <= fs;
        end
    end
    assign b_rise = bclk && !bclk_d_reg;
    assign b_fall = !bclk && bclk_d_reg;
    assign fs_rise = fs && !fs_d_reg;

    // ************************************************
    // frame alignment and bit counter
    // ************************************************
    logic armed_reg, aligned_reg;
    logic [CW-1:0] bit_cnt_reg, fall_cnt;

    // slot index that begins at this falling edge
    assign fall_cnt = armed_reg ? '0 : bit_cnt_reg + CW'(1);

    // a long strobe only arms once per rising edge
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            armed_reg <= 1'b0;
            aligned_reg <= 1'b0;
            bit_cnt_reg <= '1;
        end
        else
        begin
            if (fs_rise)
                armed_reg <= 1'b1;
            else if (b_fall)
                armed_reg <= 1'b0;
            if (b_fall)
            begin
                if (armed_reg)
                    aligned_reg <= 1'b1;
                if (armed_reg || bit_cnt_reg != '1)
                    bit_cnt_reg <= fall_cnt;
            end
        end
    end

    // ************************************************
    // slot placement
    // ************************************************
    logic wide;
    logic [5:0] len;
    logic [CW-1:0] tx_start, rx_start, tx_cnt, tx_idx, rx_idx;
    logic [5:0] tsc_len;

    assign wide = sr_reg && wb_reg;
    // sample length in bit slots
    assign len = lin_reg ? (wide ? `PHW_LEN_PAIR : `PHW_LEN_WORD)
        : (wide ? `PHW_LEN_WORD : `PHW_LEN_BYTE);
    // first bit slot of each direction
    assign tx_start = CW'({tts_reg, 3'h0}) + CW'(tcs_reg);
    assign rx_start = CW'({rts_reg, 3'h0}) + CW'(rcs_reg);
    // transmit changes at the fall, or half a bit later
    assign tx_cnt = transmit_edge_polarity_reg ? bit_cnt_reg : fall_cnt;
    assign tx_idx = tx_cnt - tx_start;
    assign rx_idx = bit_cnt_reg - rx_start;
    // whole time slots touched by the sample
    assign tsc_len = len + ((tcs_reg != 3'h0) ? `PHW_LEN_BYTE : 6'h00);

    // ************************************************
    // sample conversion
    // ************************************************
    logic [7:0] enc0, enc1;
    logic [15:0] dec0, dec1;
    logic [31:0] tx_word_reg, rx_sh_reg, rx_word_reg;
    logic rx_done_reg;

    // compander per sample of a frame
    phw_compander u_cmp0 (
        .i_mu_law(law_reg),
        .i_linear(i_tx_sample0),
        .o_code(enc0),
        .i_code(rx_word_reg[31:24]),
        .o_linear(dec0)
    );
    phw_compander u_cmp1 (
        .i_mu_law(law_reg),
        .i_linear(i_tx_sample1),
        .o_code(enc1),
        .i_code(rx_word_reg[23:16]),
        .o_linear(dec1)
    );

    // latch outgoing samples at frame start, msb leading
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            tx_word_reg <= 32'h0;
        else if (b_fall && armed_reg)
            tx_word_reg <= lin_reg ? {i_tx_sample0, i_tx_sample1}
                : {enc0, enc1, 16'h0000};
    end

    // ************************************************
    // transmit and buffer strobe
    // ************************************************
    logic last_reg;
    logic tx_edge;
    assign tx_edge = transmit_edge_polarity_reg ? b_rise : b_fall;

    // drive one bit per slot inside the window
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_serial_out_line <= 1'b0;
            o_serial_out_line_oe_n <= 1'b1;
            last_reg <= 1'b0;
        end
        else if (tx_edge)
        begin
            if (aligned_reg && in_win(tx_cnt, tx_start, len))
            begin
                o_serial_out_line <= tx_word_reg[5'(~tx_idx[4:0])];
                o_serial_out_line_oe_n <= 1'b0;
                last_reg <= (tx_idx == CW'(len) - CW'(1));
            end
            else
            begin
                o_serial_out_line_oe_n <= 1'b1;
                last_reg <= 1'b0;
            end
        end
        else if (adj_reg && last_reg && (transmit_edge_polarity_reg ? b_fall : b_rise))
        begin
            o_serial_out_line_oe_n <= 1'b1;
            last_reg <= 1'b0;
        end
    end

    // buffer enable follows whole time slot boundaries
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_buffer_drive_strobe_n <= 1'b1;
        else if (b_fall)
            o_buffer_drive_strobe_n <= !(aligned_reg || armed_reg)
                || !in_win(fall_cnt, CW'({tts_reg, 3'h0}), tsc_len);
    end

    // ************************************************
    // receive
    // ************************************************
    logic rx_edge;
    assign rx_edge = receive_edge_polarity_reg ? b_fall : b_rise;

    // shift in msb first and left align when complete
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            rx_sh_reg <= 32'h0;
            rx_word_reg <= 32'h0;
            rx_done_reg <= 1'b0;
        end
        else
        begin
            rx_done_reg <= 1'b0;
            if (rx_edge && aligned_reg && in_win(bit_cnt_reg, rx_start, len))
            begin
                rx_sh_reg <= {rx_sh_reg[30:0], i_serial_in_line};
                if (rx_idx == CW'(len) - CW'(1))
                begin
                    rx_word_reg <= {rx_sh_reg[30:0], i_serial_in_line}
                        << (6'h20 - len);
                    rx_done_reg <= 1'b1;
                end
            end
        end
    end

    // deliver received samples
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_rx_sample0 <= 16'h0;
            o_rx_sample1 <= 16'h0;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= rx_done_reg;
            if (rx_done_reg)
            begin
                o_rx_sample0 <= lin_reg ? rx_word_reg[31:16] : dec0;
                o_rx_sample1 <= lin_reg ? rx_word_reg[15:0] : dec1;
            end
        end
    end

    // ************************************************
    // rate detection and lock
    // ************************************************
    logic [3:0] frm_reg;
    logic [4:0] lock_cnt_reg;
    logic [CW-1:0] cyc_reg, ref_reg, ref_now;
    logic mis_reg, mis_now;

    assign ref_now = (frm_reg == 4'h0) ? cyc_reg : ref_reg;
    assign mis_now = mis_reg || (cyc_reg != ref_now);
    assign err_set = fs_rise && det_reg == phw_pkg::PHW_MEASURE
        && frm_reg == `PHW_N_MEASURE - 4'h1 && (mis_now || !rate_ok(ref_now));

    // count bit clocks per frame over the measure window
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            det_reg <= phw_pkg::PHW_DISCARD;
            frm_reg <= 4'h0;
            cyc_reg <= '0;
            ref_reg <= '0;
            mis_reg <= 1'b0;
            pll_reg <= `PHW_DEF_RATE;
        end
        else if (fs_rise)
        begin
            cyc_reg <= CW'(b_rise); // a rise beside the strobe opens the count
            unique case (det_reg)
                phw_pkg::PHW_DISCARD:
                begin
                    frm_reg <= frm_reg + 4'h1;
                    if (frm_reg == `PHW_N_DISCARD)
                    begin
                        det_reg <= phw_pkg::PHW_MEASURE;
                        frm_reg <= 4'h0;
                    end
                end
                phw_pkg::PHW_MEASURE:
                begin
                    ref_reg <= ref_now;
                    mis_reg <= mis_now;
                    frm_reg <= frm_reg + 4'h1;
                    if (frm_reg == `PHW_N_MEASURE - 4'h1)
                    begin
                        det_reg <= phw_pkg::PHW_DONE;
                        pll_reg <= (mis_now || !rate_ok(ref_now))
                            ? `PHW_DEF_RATE : ref_now;
                    end
                end
                phw_pkg::PHW_DONE: ;
                default: det_reg <= phw_pkg::PHW_DISCARD;
            endcase
        end
        else if (b_rise && cyc_reg != '1)
            cyc_reg <= cyc_reg + CW'(1);
    end

    // sticky error, set wins over clear, and lock after twenty frames
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            err_reg <= 1'b0;
            lock_reg <= 1'b0;
            lock_cnt_reg <= 5'h00;
            o_clock_detect_error_irq <= 1'b0;
        end
        else
        begin
            if (err_set)
                err_reg <= 1'b1;
            else if (err_clr)
                err_reg <= 1'b0;
            if (fs_rise && !lock_reg)
                lock_cnt_reg <= lock_cnt_reg + 5'h01;
            if (lock_cnt_reg == `PHW_N_LOCK)
                lock_reg <= 1'b1;
            o_clock_detect_error_irq <= err_reg && irq_en_reg;
        end
    end
endmodule // phw_port
`default_nettype wire

// ---- tb/phw_port_chk.sv ----
// assertion checker of the pcm highway port
`timescale 1ns/10ps
`default_nettype none
module phw_port_chk (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_bit_clock_output_pin,
    input wire logic o_frame_boundary_strobe,
    input wire logic o_frame_boundary_strobe_oe_n,
    input wire logic o_serial_out_line_oe_n,
    input wire logic o_buffer_drive_strobe_n,
    input wire logic [15:0] o_rx_sample0,
    input wire logic o_rx_valid,
    input wire logic o_clock_detect_error_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    // read data only in the cycle after a read
    AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data without read");
    AST_RST_QUIET: assert property ($fell(i_sys_rst) |-> o_serial_out_line_oe_n
        && o_buffer_drive_strobe_n && !o_clock_detect_error_irq) else $error("reset outputs");
    AST_SLAVE_DEFAULT: assert property ($fell(i_sys_rst) |->
        o_frame_boundary_strobe_oe_n && !o_bit_clock_output_pin) else $error("not slave");
    AST_VALID_PULSE: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("valid too long");
    AST_RX_HOLD: assert property (!o_rx_valid |-> $stable(o_rx_sample0))
        else $error("sample moved");
    AST_DIV_CLOCK: assert property ($changed(o_bit_clock_output_pin) |=>
        $stable(o_bit_clock_output_pin)[*8]) else $error("clock not divided");
    AST_MFS_LEN: assert property ($rose(o_frame_boundary_strobe) |->
        ##[90:105] $fell(o_frame_boundary_strobe)) else $error("strobe length");
    AST_TX_IN_SLOT: assert property ($fell(o_serial_out_line_oe_n) |->
        !o_buffer_drive_strobe_n) else $error("drive outside slot");
    // main scenarios
    cover property (o_rx_valid);
    cover property ($fell(o_serial_out_line_oe_n));
    cover property ($rose(o_frame_boundary_strobe));
endmodule // phw_port_chk
bind phw_port phw_port_chk phw_port_chk_inst (.*);
`default_nettype wire

// ---- tb/phw_hwy_model.sv ----
// highway partner: bit clock, frame strobe, data and capture
`timescale 1ns/10ps
`default_nettype none
module phw_hwy_model #(
    parameter logic [63:0] PAT = 64'h0
) (
    // device side
    input wire logic i_dout,
    input wire logic i_dout_oe_n,
    input wire logic i_bstb_n,
    output logic o_bclk,
    output logic o_fs,
    output logic o_din,
    // what the last frame carried
    output logic [63:0] o_cap,
    output logic [63:0] o_map,
    output logic [63:0] o_smap
);
    logic [5:0] slot = 6'h00;
    logic [63:0] sr = 64'h0;
    logic [63:0] map = 64'h0;
    logic [63:0] smap = 64'h0;
    // clock runs through reset, 64 bits a frame
    initial
    begin
        {o_fs, o_din, o_cap, o_map, o_smap} = '0;
        o_bclk = 1'b1;
        forever #20 o_bclk = ~o_bclk;
    end
    // strobe and capture on rises
    always @(posedge o_bclk)
    begin
        o_fs <= (slot == 6'h3f);
        map[6'h3f - slot] = !i_dout_oe_n;
        smap[6'h3f - slot] = !i_bstb_n;
        if (!i_dout_oe_n)
            sr = {sr[62:0], i_dout};
    end
    // data and frame turnover on falls
    always @(negedge o_bclk)
    begin
        slot = slot + 6'h01;
        o_din <= PAT[6'h3f - slot];
        if (slot == 6'h00)
        begin
            o_cap <= sr;
            o_map <= map;
            o_smap <= smap;
            sr = 64'h0;
        end
    end
endmodule // phw_hwy_model
`default_nettype wire

// ---- tb/phw_port_test.sv ----
// self-checking bench of the pcm highway port
`timescale 1ns/10ps
`default_nettype none
`include "phw_consts.svh"
module phw_port_test;
    localparam logic [63:0] PAT = 64'hc3a5_6b2d_1e87_f049;
    logic clk, rst, wr, rd, mstr, mck, irq, fo, fo_oe_n, dout, dout_oe_n, bstb_n, bclk, fs, din;
    logic [7:0] addr, wdata, rdata, d;
    logic [15:0] s0, s1, r0, r1;
    logic [63:0] cap, map, smap;
    logic bco;
    int mismatches, total_checks, n;
    wire logic bin;
    assign bin = mstr ? mck : bclk;
    phw_port phw_port_inst (.i_mclk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_bit_clock_input_pin(bin), .o_bit_clock_output_pin(bco), .i_frame_boundary_strobe(fs),
        .o_frame_boundary_strobe(fo), .o_frame_boundary_strobe_oe_n(fo_oe_n),
        .i_serial_in_line(din), .o_serial_out_line(dout), .o_serial_out_line_oe_n(dout_oe_n),
        .o_buffer_drive_strobe_n(bstb_n), .i_tx_sample0(s0), .i_tx_sample1(s1),
        .o_rx_sample0(r0), .o_rx_sample1(r1), .o_rx_valid(), .o_clock_detect_error_irq(irq));
    phw_hwy_model #(.PAT(PAT)) phw_hwy_model_inst (.i_dout(dout), .i_dout_oe_n(dout_oe_n),
        .i_bstb_n(bstb_n), .o_bclk(bclk), .o_fs(fs), .o_din(din), .o_cap(cap), .o_map(map),
        .o_smap(smap));
    // 200 MHz system clock and 4.096 MHz master clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        mck = 1'b0;
        forever #122 mck = ~mck;
    end
    task automatic chk(input logic [63:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // bit slots f to f+n-1 of a frame
    function automatic logic [63:0] span(input int f, input int n);
        logic [63:0] s;
        s = 64'h0;
        for (int i = f; i < f + n; i++)
            s[63 - i] = 1'b1;
        return s;
    endfunction
    // one transmit format, slot 8*1+2 = 10
    task automatic tcase(input logic [7:0] m, r, input logic [63:0] e, input int n);
        wr_reg(`PHW_A_MODE, m);
        wr_reg(`PHW_A_RATE, r & 8'h01);
        wr_reg(`PHW_A_RATE, r);
        repeat (3 * 512) @(posedge clk);
        chk(cap, e);
        chk(map, span(10, n));
        chk(smap, span(8, n + 8));
    endtask
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        conclude();
    end
    // test sequence
    initial
    begin
        {rst, wr, rd, mstr, addr, wdata, s0, s1} = {4'b1000, 48'h0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`PHW_A_IRQEN, d);
        chk(64'(d[4]), 64'h1);
        rd_reg(`PHW_A_MODE, d);
        chk(64'(d), 64'h0);
        rd_reg(8'h7f, d);
        chk(64'(d), 64'h0);
        wr_reg(`PHW_A_TTS, 8'h01);
        wr_reg(`PHW_A_TCS, 8'h02);
        wr_reg(`PHW_A_RCS, 8'h03);
        repeat (24 * 512) @(posedge clk);
        rd_reg(`PHW_A_STAT, d);
        chk(64'(d[2:0]), 64'h5);
        rd_reg(`PHW_A_PLLL, d);
        chk(64'(d), 64'h40);
        chk(64'(irq), 64'h0);
        s0 <= 16'ha5c3;
        s1 <= 16'h3c5a;
        tcase(8'h02, 8'h00, 64'ha5c3, 16);
        tcase(8'h02, 8'h03, 64'ha5c3_3c5a, 32);
        chk(64'(r0), 64'(PAT[60 -: 16]));
        chk(64'(r1), 64'(PAT[44 -: 16]));
        s0 <= 16'h0000;
        s1 <= 16'h0000;
        tcase(8'h00, 8'h00, 64'hd5, 8);
        tcase(8'h01, 8'h03, 64'hffff, 16);
        mstr <= 1'b1;
        wr_reg(`PHW_A_MODE, 8'h40);
        for (n = 0; !fo && n < 30000; n++)
            @(negedge clk);
        for (n = 0; fo && n < 200; n++)
            @(negedge clk);
        chk(64'(fo_oe_n), 64'h0);
        chk(64'(n >= 95 && n <= 100), 64'h1);
        // divided clock high for half of a 2.048 MHz period
        for (n = 0; !bco && n < 200; n++)
            @(negedge clk);
        for (n = 0; bco && n < 200; n++)
            @(negedge clk);
        chk(64'(n >= 46 && n <= 51), 64'h1);
        conclude();
    end
endmodule // phw_port_test
`default_nettype wire
